/* adc_power_interface_mode_regs_bench.sv */
// Self-checking bench of the power, interface and conversion_mode_zero configuration registers.
`timescale 1ns/1ns
`include "conv_cfg_map.svh"
`define check_eq(what, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module adc_power_interface_mode_regs_bench;
   // *****
   // Signals and model state
   // *****
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic conv_start_req = 1'b0, conv_stop_req = 1'b0, conversion_done = 1'b0;
   logic reg_wr_en, reg_rd_en, block_write, cmd_complete, cmd_abort, reg_rd_valid;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic level_shift_enable, internal_reference_enable, excitation_ref_ok;
   logic interface_timeout_enable, status_byte_enable, reference_polarity_reverse;
   logic conversion_run_select, input_chop_enable, current_rotation_enable;
   logic primary_convert_pulse, conversion_active, data_ready_out;
   conv_cfg_pkg::trailer_e trailer_mode;
   int num_errors = 0;
   int checks = 0;
   int pwr, ifc, m0, pend;
   // Short delay table, so every code fits in a brief run.
   localparam conv_cfg_pkg::delay_cnt_t dly [12] = '{21'd0, 21'd2, 21'd3, 21'd4, 21'd5,
      21'd6, 21'd7, 21'd8, 21'd9, 21'd10, 21'd11, 21'd12};

   // 125 MHz clock.
   always #4 clk = ~clk;

   conv_host_model host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .block_write(block_write),
      .cmd_complete(cmd_complete), .cmd_abort(cmd_abort), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid));

   conv_cfg_regs #(.DELAY_CYCLES(dly)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .block_write(block_write), .cmd_complete(cmd_complete),
      .cmd_abort(cmd_abort), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .conv_start_req(conv_start_req), .conv_stop_req(conv_stop_req),
      .conversion_done(conversion_done), .level_shift_enable(level_shift_enable),
      .internal_reference_enable(internal_reference_enable),
      .excitation_ref_ok(excitation_ref_ok), .trailer_mode(trailer_mode),
      .interface_timeout_enable(interface_timeout_enable),
      .status_byte_enable(status_byte_enable), .input_chop_enable(input_chop_enable),
      .reference_polarity_reverse(reference_polarity_reverse),
      .conversion_run_select(conversion_run_select), .conversion_active(conversion_active),
      .current_rotation_enable(current_rotation_enable),
      .primary_convert_pulse(primary_convert_pulse), .data_ready_out(data_ready_out));

   // *****
   // Tasks
   // *****
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Six-cycle reset; the model returns to the documented defaults.
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      pwr = 'h11;
      ifc = 'h05;
      m0 = 'h00;
   endtask

   // Write through the host and update the model; the indicator bit can only be cleared.
   task automatic mwr(int a, int d, bit blk);
      host.wr(5'(a), 8'(d), blk);
      if (a == 1) pwr = (pwr & d & 'h10) | (d & 'h03);
      else if (a == 2) ifc = d & 'h0f;
      else if (a == 3 && blk) pend = d & 'hff;
      else if (a == 3) m0 = d & 'hff;
   endtask

   // Reads all three registers back and compares every configuration pin with the model.
   task automatic check_all();
      logic [7:0] d;
      logic v;
      int exp [3];
      exp = '{pwr, ifc, m0};
      for (int a = 1; a <= 3; a++) begin
         host.rd(5'(a), d, v);
         `check_eq("read valid", 1'b1, v)
         `check_eq("register", exp[a-1][7:0], d)
      end
      `check_eq("pins", {pwr[1], pwr[0], pwr[0], ifc[3], ifc[2], ifc[1:0], m0[7:4]}, {level_shift_enable, internal_reference_enable, excitation_ref_ok, interface_timeout_enable, status_byte_enable, trailer_mode, reference_polarity_reverse, conversion_run_select, current_rotation_enable, input_chop_enable})
   endtask

   // One-cycle request pulse: 0 start, 1 result done, 2 stop.
   task automatic tap(int which);
      @(posedge clk);
      conv_start_req <= (which == 0);
      conversion_done <= (which == 1);
      conv_stop_req <= (which == 2);
      @(posedge clk);
      {conv_start_req, conversion_done, conv_stop_req} <= 3'h0;
      #1;
   endtask

   // Counts edges from the taking edge to the conversion pulse, within a bound.
   task automatic wait_pulse(int n_exp);
      int n;
      n = 0;
      while (n < 40) begin
         @(posedge clk);
         #1;
         n++;
         if (primary_convert_pulse === 1'b1) break;
      end
      `check_eq("start delay", n_exp, n)
   endtask

   // *****
   // Watchdog and main sequence
   // *****
   // A hang ends the run as a failure well past the expected few hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("mismatch watchdog expected done seen hang");
      results();
   end

   initial begin
      logic [7:0] d;
      logic v;
      int r;
      int codes [5];
      codes = '{0, 1, 11, 12, 15};
      void'($urandom(37513));
      do_reset();
      check_all();
      // Unmapped places ignore writes and read zero.
      mwr(4, 'hff, 0);
      foreach (codes[i]) begin
         host.rd(5'(codes[i] == 15 ? 31 : codes[i] == 1 ? 4 : 0), d, v);
         `check_eq("unmapped", 8'h00, d)
      end
      // Random bytes with reserved bits set; every checksum and chop code is visited.
      host.rude = 1'b1;
      for (int i = 0; i < 12; i++) begin
         r = $urandom();
         mwr(2, (r & 'hfc) | (i & 3), 0);
         mwr(3, (r & 'hcf) | ((i & 3) << 4), 0);
         mwr(1, r >> 8, 0);
         check_all();
      end
      host.rude = 1'b0;
      // A low clock enable freezes the registers, so this write is lost.
      ce <= 1'b0;
      host.wr(5'h02, 8'h08, 1'b0);
      ce <= 1'b1;
      check_all();
      // A cleared indicator stays clear until a reset, mid-run reset included.
      mwr(1, 'h00, 0);
      mwr(1, 'h13, 0);
      check_all();
      do_reset();
      check_all();
      // Block writes apply at completion and are dropped on abort.
      mwr(3, 'h5a, 1);
      check_all();
      host.cmd(1'b0);
      m0 = pend;
      check_all();
      mwr(3, 'hc3, 1);
      host.cmd(1'b1);
      check_all();
      // One-shot starts across the delay codes, reserved ones included.
      foreach (codes[i]) begin
         mwr(3, 'h40 | codes[i], 0);
         tap(0);
         `check_eq("ready high", 1'b1, data_ready_out)
         `check_eq("running", 1'b1, conversion_active)
         wait_pulse(codes[i] < 12 ? int'(dly[codes[i]]) + 1 : 1);
         tap(1);
         `check_eq("ready low", 1'b0, data_ready_out)
         `check_eq("one shot stop", 1'b0, conversion_active)
         tap(2);
      end
      // Continuous mode restarts after each result; a conversion_mode_zero write restarts it too.
      mwr(3, 'h01, 0);
      tap(0);
      wait_pulse(int'(dly[1]) + 1);
      tap(1);
      wait_pulse(int'(dly[1]) + 1);
      mwr(3, 'h82, 0);
      #1;
      `check_eq("restart ready", 1'b1, data_ready_out)
      wait_pulse(int'(dly[2]) + 1);
      tap(2);
      check_all();
      results();
   end
endmodule

/* conv_cfg_map.svh */
// Register offsets, field positions, reset values and timing constants of the converter config slice.
`ifndef CONV_CFG_MAP_SVH
`define CONV_CFG_MAP_SVH

// ****************************************
// Register offsets on the command port
// ****************************************
`define POWER_OFS 5'h01
`define IFACE_OFS 5'h02
`define CONVERSION_MODE_ZERO_OFS 5'h03

// ****************************************
// Field positions
// ****************************************
`define PWR_RSTIND_BIT 4
`define PWR_LSH_BIT 1
`define PWR_IREF_BIT 0
`define IF_TIMEOUT_BIT 3
`define IF_STATUS_BIT 2
`define IF_CRC_MSB 1
`define IF_CRC_LSB 0
`define M0_REFERENCE_POLARITY_REVERSE_BIT 7
`define M0_RUN_BIT 6
`define M0_ROTATE_BIT 5
`define M0_CHOP_BIT 4
`define M0_DELAY_MSB 3
`define M0_DELAY_LSB 0

// ****************************************
// Reset values
// ****************************************
`define PWR_RESET 8'h11
`define IFACE_RESET 8'h05
`define CONVERSION_MODE_ZERO_RESET 8'h00

// ****************************************
// Conversion start delays, in ns, per code
// ****************************************
`define CLK_FREQ_MHZ 125
`define DLY_T1_NS 8700
`define DLY_T2_NS 17000
`define DLY_T3_NS 35000
`define DLY_T4_NS 69000
`define DLY_T5_NS 139000
`define DLY_T6_NS 278000
`define DLY_T7_NS 555000
`define DLY_T8_NS 1100000
`define DLY_T9_NS 2200000
`define DLY_T10_NS 4400000
`define DLY_T11_NS 8800000
`define DLY_CODE_LAST 4'hb
// A least wait, so the cycle count rounds up.
`define NS_TO_CYC(t) (((t) * `CLK_FREQ_MHZ + 999) / 1000)

`endif

/* conv_cfg_pkg.sv */
// Types shared by the converter config slice and its start-delay timer.
package conv_cfg_pkg;

   // Cycle count of one start delay; the longest wait needs 21 bits.
   typedef logic [20:0] delay_cnt_t;

   // Trailing read-back byte selection.
   typedef enum logic [1:0] {
      TRAIL_NONE = 2'b00,
      TRAIL_SUM = 2'b01,
      TRAIL_CRC = 2'b10,
      TRAIL_RSVD = 2'b11
   } trailer_e;

   // Start-delay timer states.
   typedef enum logic {
      SEQ_IDLE = 1'b0,
      SEQ_WAIT = 1'b1
   } seq_state_e;

endpackage

/* conv_cfg_regs.sv */
// Power, serial-interface and conversion_mode_zero configuration registers with conversion sequencing.
`timescale 1ns/1ns
`include "conv_cfg_map.svh"
module conv_cfg_regs #(
   parameter conv_cfg_pkg::delay_cnt_t DELAY_CYCLES [12] = '{
      21'h000000,
      21'(`NS_TO_CYC(`DLY_T1_NS)),
      21'(`NS_TO_CYC(`DLY_T2_NS)),
      21'(`NS_TO_CYC(`DLY_T3_NS)),
      21'(`NS_TO_CYC(`DLY_T4_NS)),
      21'(`NS_TO_CYC(`DLY_T5_NS)),
      21'(`NS_TO_CYC(`DLY_T6_NS)),
      21'(`NS_TO_CYC(`DLY_T7_NS)),
      21'(`NS_TO_CYC(`DLY_T8_NS)),
      21'(`NS_TO_CYC(`DLY_T9_NS)),
      21'(`NS_TO_CYC(`DLY_T10_NS)),
      21'(`NS_TO_CYC(`DLY_T11_NS))}
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port from the serial command decoder.
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic block_write,
   input wire logic cmd_complete,
   input wire logic cmd_abort,
   output logic [7:0] reg_rdata,
   output logic reg_rd_valid,
   // Conversion control from the command decoder and the modulator.
   input wire logic conv_start_req,
   input wire logic conv_stop_req,
   input wire logic conversion_done,
   // Analog bias and reference controls.
   output logic level_shift_enable,
   output logic internal_reference_enable,
   output logic excitation_ref_ok,
   // Read-back framing controls.
   output logic interface_timeout_enable,
   output logic status_byte_enable,
   output conv_cfg_pkg::trailer_e trailer_mode,
   // Primary converter controls.
   output logic reference_polarity_reverse,
   output logic conversion_run_select,
   output logic input_chop_enable,
   output logic current_rotation_enable,
   output logic primary_convert_pulse,
   output logic conversion_active,
   output logic data_ready_out
);

   // ****************************************
   // Storage
   // ****************************************

   logic rst_ind_reg; // Reset indicator, sticky until the host clears it.
   logic lsh_reg; // Level shift enable.
   logic iref_reg; // Internal reference enable.
   logic [3:0] iface_reg; // Writable low nibble of the interface register.
   logic [7:0] conversion_mode_zero_reg; // Live conversion_mode_zero value.
   logic [7:0] conversion_mode_zero_shadow_reg; // Conversion_mode_zero value held during a block write.
   logic conversion_mode_zero_pending_reg; // A block-written conversion_mode_zero waits for completion.
   logic [7:0] conversion_mode_zero_next; // Conversion_mode_zero value in force from the next cycle.
   logic running_reg; // Conversions have been started and not stopped.
   logic data_ready_out_reg; // Data ready, high while no fresh result is waiting.
   logic pulse_reg; // One-cycle conversion begin.
   logic [7:0] rdata_reg; // Read data.
   logic rvalid_reg; // Read data valid.

   conv_seq_if seq ();

   // Address decode, shared by write and read paths.
   function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
      hit = (addr == ofs);
   endfunction

   logic pwr_wr; // Write to the power register.
   logic if_wr; // Write to the interface register.
   logic m0_wr; // Write to conversion_mode_zero.
   logic m0_direct; // Conversion_mode_zero write that takes effect at once.
   logic m0_commit; // Buffered conversion_mode_zero taking effect at completion.
   logic mode_apply; // Conversion_mode_zero changes this cycle.
   logic restart_req; // Running conversion must restart.

   assign pwr_wr = ce && reg_wr_en && hit(reg_addr, `POWER_OFS);
   assign if_wr = ce && reg_wr_en && hit(reg_addr, `IFACE_OFS);
   assign m0_wr = ce && reg_wr_en && hit(reg_addr, `CONVERSION_MODE_ZERO_OFS);
   assign m0_direct = m0_wr && !block_write;
   assign m0_commit = ce && conversion_mode_zero_pending_reg && cmd_complete && !cmd_abort;
   assign mode_apply = m0_direct || m0_commit;
   assign restart_req = mode_apply && running_reg;

   // ****************************************
   // Power register
   // ****************************************

   // Only a write of zero touches the indicator; a one written by the host is ignored,
   // so the bit can only return to one through a device reset.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rst_ind_reg <= 1'b1;
      end else if (pwr_wr && !reg_wdata[`PWR_RSTIND_BIT]) begin
         rst_ind_reg <= 1'b0;
      end
   end

   // Enables for the analog bias and the reference; reserved bits are not stored.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lsh_reg <= 1'(`PWR_RESET >> `PWR_LSH_BIT);
         iref_reg <= 1'(`PWR_RESET >> `PWR_IREF_BIT);
      end else if (pwr_wr) begin
         lsh_reg <= reg_wdata[`PWR_LSH_BIT];
         iref_reg <= reg_wdata[`PWR_IREF_BIT];
      end
   end

   // ****************************************
   // Interface register
   // ****************************************

   // The reserved code 11 of the checksum field is stored as written; framing treats it
   // as reserved and the read-back shows exactly what the host wrote.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         iface_reg <= 4'(`IFACE_RESET);
      end else if (if_wr) begin
         iface_reg <= reg_wdata[3:0];
      end
   end

   // ****************************************
   // Conversion_mode_zero with group update
   // ****************************************

   always_comb begin
      conversion_mode_zero_next = conversion_mode_zero_reg;
      if (m0_direct) begin
         conversion_mode_zero_next = reg_wdata;
      end else if (m0_commit) begin
         conversion_mode_zero_next = conversion_mode_zero_shadow_reg;
      end
   end

   // Conversion_mode_zero is part of the group set: a block write only changes the live value when the
   // whole command completes, which keeps the converter from restarting per byte.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conversion_mode_zero_reg <= `CONVERSION_MODE_ZERO_RESET;
      end else begin
         conversion_mode_zero_reg <= conversion_mode_zero_next;
      end
   end

   // A new block write wins over a completion or abort in the same cycle.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conversion_mode_zero_shadow_reg <= `CONVERSION_MODE_ZERO_RESET;
         conversion_mode_zero_pending_reg <= 1'b0;
      end else if (m0_wr && block_write) begin
         conversion_mode_zero_shadow_reg <= reg_wdata;
         conversion_mode_zero_pending_reg <= 1'b1;
      end else if (ce && (cmd_complete || cmd_abort)) begin
         conversion_mode_zero_pending_reg <= 1'b0;
      end
   end

   // ****************************************
   // Conversion sequencing
   // ****************************************

   // The restart uses the conversion_mode_zero value just written so that its delay applies at once.
   assign seq.start = ce && !conv_stop_req && (conv_start_req || restart_req
      || (conversion_done && running_reg && !conversion_mode_zero_reg[`M0_RUN_BIT]));
   assign seq.cancel = ce && conv_stop_req;
   assign seq.delay_code = conversion_mode_zero_next[`M0_DELAY_MSB:`M0_DELAY_LSB];

   // Single-shot mode stops after one result; continuous mode keeps going until stopped.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         running_reg <= 1'b0;
      end else if (ce) begin
         if (conv_stop_req) begin
            running_reg <= 1'b0;
         end else if (conv_start_req) begin
            running_reg <= 1'b1;
         end else if (conversion_done && conversion_mode_zero_reg[`M0_RUN_BIT]) begin
            running_reg <= 1'b0;
         end
      end
   end

   // Data ready goes low when a result lands and high on a start or a restart; the high
   // wins so a restart never leaves a stale result flagged as fresh.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         data_ready_out_reg <= 1'b1;
      end else if (ce) begin
         if (conv_start_req || restart_req) begin
            data_ready_out_reg <= 1'b1;
         end else if (conversion_done) begin
            data_ready_out_reg <= 1'b0;
         end
      end
   end

   // Registered begin pulse toward the modulator.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_reg <= 1'b0;
      end else if (ce) begin
         pulse_reg <= seq.go && running_reg;
      end
   end

   conv_delay_timer #(
      .DELAY_CYCLES(DELAY_CYCLES)
   ) delay_timer (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .seq(seq)
   );

   // ****************************************
   // Read-back
   // ****************************************

   // Reserved bits are built as constant zeros; unmapped offsets read zero.
   // A low enable freezes the valid flag as well, so a paused read is not lost.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else if (ce) begin
         rvalid_reg <= reg_rd_en;
         if (reg_rd_en) begin
            rdata_reg <= 8'h00;
            if (hit(reg_addr, `POWER_OFS)) begin
               rdata_reg <= {3'h0, rst_ind_reg, 2'h0, lsh_reg, iref_reg};
            end else if (hit(reg_addr, `IFACE_OFS)) begin
               rdata_reg <= {4'h0, iface_reg};
            end else if (hit(reg_addr, `CONVERSION_MODE_ZERO_OFS)) begin
               rdata_reg <= conversion_mode_zero_reg;
            end
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   assign reg_rdata = rdata_reg;
   assign reg_rd_valid = rvalid_reg;
   assign level_shift_enable = lsh_reg;
   assign internal_reference_enable = iref_reg;
   // Excitation currents and the temperature sensor need the reference running.
   assign excitation_ref_ok = iref_reg;
   assign interface_timeout_enable = iface_reg[`IF_TIMEOUT_BIT];
   assign status_byte_enable = iface_reg[`IF_STATUS_BIT];
   assign trailer_mode = conv_cfg_pkg::trailer_e'(iface_reg[`IF_CRC_MSB:`IF_CRC_LSB]);
   assign reference_polarity_reverse = conversion_mode_zero_reg[`M0_REFERENCE_POLARITY_REVERSE_BIT];
   assign conversion_run_select = conversion_mode_zero_reg[`M0_RUN_BIT];
   assign input_chop_enable = conversion_mode_zero_reg[`M0_CHOP_BIT];
   assign current_rotation_enable = conversion_mode_zero_reg[`M0_ROTATE_BIT];
   assign primary_convert_pulse = pulse_reg;
   assign conversion_active = running_reg;
   assign data_ready_out = data_ready_out_reg;

   // ****************************************
   // Checks
   // ****************************************

   sequence block_conversion_mode_zero_write;
      m0_wr && block_write;
   endsequence

   sequence aborted_command;
      ce && cmd_abort && !m0_wr;
   endsequence

   chk_reset_sets_flag: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> rst_ind_reg && iref_reg && !lsh_reg)
      else $error("Power register did not come out of reset as 11h.");

   chk_flag_stays_clear: assert property (@(posedge clk) disable iff (!rst_n)
      !rst_ind_reg |=> !rst_ind_reg)
      else $error("Reset indicator returned to one without a reset.");

   chk_reset_values: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> (iface_reg == 4'h5) && (conversion_mode_zero_reg == 8'h00))
      else $error("Interface or conversion_mode_zero reset value wrong.");

   chk_group_abort_drop: assert property (@(posedge clk) disable iff (!rst_n)
      block_conversion_mode_zero_write ##[1:2] aborted_command |=> $stable(conversion_mode_zero_reg) && !conversion_mode_zero_pending_reg)
      else $error("Aborted block write changed conversion_mode_zero.");

   chk_group_hold_value: assert property (@(posedge clk) disable iff (!rst_n)
      block_conversion_mode_zero_write |=> (conversion_mode_zero_reg == $past(conversion_mode_zero_reg)))
      else $error("Block-written conversion_mode_zero took effect before completion.");

   chk_group_commit: assert property (@(posedge clk) disable iff (!rst_n)
      m0_commit && !m0_direct |=> (conversion_mode_zero_reg == $past(conversion_mode_zero_shadow_reg)))
      else $error("Completed block write did not update conversion_mode_zero.");

   chk_restart_ready: assert property (@(posedge clk) disable iff (!rst_n)
      restart_req |=> data_ready_out ##1 (seq.busy || pulse_reg || !ce || !running_reg))
      else $error("Conversion_mode_zero write did not restart the conversion.");

   chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
      ce && reg_rd_en && hit(reg_addr, `POWER_OFS) |=> (reg_rdata[7:5] == 3'h0)
         && (reg_rdata[3:2] == 2'h0) && reg_rd_valid)
      else $error("Reserved power bits read back nonzero.");

   chk_single_shot_stop: assert property (@(posedge clk) disable iff (!rst_n)
      ce && conversion_done && conversion_run_select && !conv_start_req |=> !running_reg)
      else $error("Single-shot mode kept converting after a result.");

endmodule

/* conv_delay_timer.sv */
// Programmable wait between conversion start and the actual conversion.
`timescale 1ns/1ns
`include "conv_cfg_map.svh"
module conv_delay_timer #(
   parameter conv_cfg_pkg::delay_cnt_t DELAY_CYCLES [12] = '{12{21'h000000}}
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Link to the register block.
   conv_seq_if.timer seq
);

   conv_cfg_pkg::seq_state_e state_reg; // Waiting or idle.
   conv_cfg_pkg::delay_cnt_t cnt_reg; // Cycles still to wait.
   conv_cfg_pkg::delay_cnt_t loaded_reg; // Count taken at start, kept for checking.
   conv_cfg_pkg::delay_cnt_t elapsed_reg; // Enabled cycles spent waiting.

   // Codes past the table are reserved; they start at once rather than guess a length.
   function automatic conv_cfg_pkg::delay_cnt_t delay_lookup(input logic [3:0] code);
      delay_lookup = 21'h000000;
      if (code <= `DLY_CODE_LAST) begin
         delay_lookup = DELAY_CYCLES[code];
      end
   endfunction

   // ****************************************
   // Countdown
   // ****************************************

   // A fresh start reloads the count, so a restart always begins a full wait.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= conv_cfg_pkg::SEQ_IDLE;
         cnt_reg <= 21'h000000;
         loaded_reg <= 21'h000000;
      end else if (ce) begin
         if (seq.start) begin
            state_reg <= conv_cfg_pkg::SEQ_WAIT;
            cnt_reg <= delay_lookup(seq.delay_code);
            loaded_reg <= delay_lookup(seq.delay_code);
         end else if (seq.cancel) begin
            state_reg <= conv_cfg_pkg::SEQ_IDLE;
         end else if (state_reg == conv_cfg_pkg::SEQ_WAIT) begin
            if (cnt_reg == 21'h000000) begin
               state_reg <= conv_cfg_pkg::SEQ_IDLE;
            end else begin
               cnt_reg <= cnt_reg - 21'h000001;
            end
         end
      end
   end

   // Count of waited cycles, read only by the checks below.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         elapsed_reg <= 21'h000000;
      end else if (ce) begin
         if (seq.start) begin
            elapsed_reg <= 21'h000000;
         end else if (state_reg == conv_cfg_pkg::SEQ_WAIT) begin
            elapsed_reg <= elapsed_reg + 21'h000001;
         end
      end
   end

   // The go pulse is one enabled cycle, the last of the wait.
   assign seq.go = ce && (state_reg == conv_cfg_pkg::SEQ_WAIT) && (cnt_reg == 21'h000000)
      && !seq.start && !seq.cancel;
   assign seq.busy = (state_reg == conv_cfg_pkg::SEQ_WAIT);

   // ****************************************
   // Checks
   // ****************************************

   sequence zero_delay_start;
      ce && seq.start && (seq.delay_code == 4'h0);
   endsequence

   sequence quiet_step;
      ce && !seq.start && !seq.cancel;
   endsequence

   chk_delay_length: assert property (@(posedge clk) disable iff (!rst_n)
      seq.go |-> (elapsed_reg == loaded_reg))
      else $error("Conversion began after the wrong number of cycles.");

   chk_zero_delay_go: assert property (@(posedge clk) disable iff (!rst_n)
      zero_delay_start ##1 quiet_step |-> seq.go)
      else $error("Delay code zero did not start the conversion at once.");

endmodule

/* conv_host_model.sv */
// Host controller model that drives the register command port of the config slice.
`timescale 1ns/1ns
`include "conv_cfg_map.svh"
module conv_host_model (
   // Clock.
   input wire logic clk,
   // Register command port toward the device.
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [4:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic block_write,
   output logic cmd_complete,
   output logic cmd_abort,
   // Read answer from the device.
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rd_valid
);
   // When set, reserved bits go out as given, so a scenario can prove they are ignored.
   logic rude = 1'b0;

   // The port idles from time zero; no strobe may float before reset ends.
   initial begin
      {reg_wr_en, reg_rd_en, block_write, cmd_complete, cmd_abort} = 5'h00;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
   end

   // One register byte; the strobe stands for exactly one taking edge.
   task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic blk);
      logic [7:0] m;
      m = (a == `POWER_OFS) ? 8'h13 : (a == `IFACE_OFS) ? 8'h0f : 8'hff;
      @(posedge clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= rude ? d : (d & m);
      block_write <= blk;
      @(posedge clk);
      reg_wr_en <= 1'b0;
      block_write <= 1'b0;
   endtask

   // One register read; the answer is taken at the edge at which the valid pulse stands.
   task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
      v = reg_rd_valid;
   endtask

   // Ends a block command, normally or cut short.
   task automatic cmd(input logic abort);
      @(posedge clk);
      cmd_complete <= ~abort;
      cmd_abort <= abort;
      @(posedge clk);
      cmd_complete <= 1'b0;
      cmd_abort <= 1'b0;
   endtask
endmodule

/* conv_seq_if.sv */
// Carrier between the config registers and the conversion start-delay timer.
`timescale 1ns/1ns
interface conv_seq_if;
   logic start; // Begin (or restart) a delayed conversion start.
   logic cancel; // Abandon a pending start.
   logic [3:0] delay_code; // Delay code taken with start.
   logic go; // The delay has run out: begin the conversion now.
   logic busy; // A delay is running.

   modport ctrl (output start, output cancel, output delay_code, input go, input busy);
   modport timer (input start, input cancel, input delay_code, output go, output busy);
endinterface
